// File: rtl/slpc_controller.sv
// sleep mode, wake-up and power-reduction controller top
//
// The address map and register access over Wishbone were left to the implementer.
module slpc_controller #(
	parameter int START_CYC = slpc_pkg::START_CYC,
	parameter int BOD_WAKE_CYC = slpc_pkg::BOD_WAKE_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [31:0] wbAdr,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	input wire logic wbWe,
	input wire logic [3:0] wbSel,
	input wire logic wbCyc,
	input wire logic wbStb,
	output logic wbAck,
	input wire logic sleepInstr,
	input wire slpc_pkg::slpc_wake_type wakeSrc,
	output slpc_pkg::slpc_clk_type clkEn,
	output logic coreHold,
	output logic irqGo,
	output logic convStart,
	output logic convExtended,
	output logic brownoutEn,
	output logic comparatorEn,
	output logic vrefEn,
	output logic timerRegBlock,
	output logic convRegBlock
);
	// ****************************************************
	// declarations
	// ****************************************************
	slpc_pkg::slpc_state_type state_q, state_d;
	slpc_pkg::slpc_mode_type sleepMode_q;
	slpc_pkg::slpc_wake_type wakeMeta_q, wakeSync_q;
	slpc_pkg::slpc_clk_type clkEn_d;
	logic [7:0] coreCtrl_q, clkGate_q, analogCtrl_q;
	logic [15:0] waitCnt_q;
	logic [2:0] haltCnt_q, unlockCnt_q, bodSeq_q;
	logic bodOffSleep_q, ack_q, irqGo_q, convStart_q, convExt_q;
	logic [31:0] rdat_q;
	logic brownoutEn_q, comparatorEn_q, vrefEn_q;

	// ****************************************************
	// wishbone decode
	// ****************************************************
	wire logic [7:0] regIdx = wbAdr[9:2];
	wire logic busReq = wbCyc && wbStb && !ack_q;
	// a write lands on the edge where the master sees ack high, not before
	wire logic wrByte = wbCyc && wbStb && ack_q && wbWe && wbSel[0];
	wire logic [7:0] wdat = wbDatW[7:0];
	wire logic wrCore = wrByte && regIdx == slpc_pkg::CORE_CTRL_IDX;
	wire logic wrGate = wrByte && regIdx == slpc_pkg::CLK_GATE_IDX;
	wire logic wrBod = wrByte && regIdx == slpc_pkg::BOD_CTRL_IDX;
	wire logic wrAnalog = wrByte && regIdx == slpc_pkg::ANALOG_CTRL_IDX;
	wire logic bodActive = bodSeq_q != 3'h0
		&& bodSeq_q <= slpc_pkg::BOD_ACTIVE_MAX;
	wire logic [7:0] bodRead = {6'h00, bodActive, unlockCnt_q != 3'h0};
	wire logic [7:0] statusRead = {3'h0, bodOffSleep_q, sleepMode_q,
		state_q};
	wire logic [7:0] rdByte =
		regIdx == slpc_pkg::CORE_CTRL_IDX ? coreCtrl_q :
		regIdx == slpc_pkg::CLK_GATE_IDX ? clkGate_q :
		regIdx == slpc_pkg::BOD_CTRL_IDX ? bodRead :
		regIdx == slpc_pkg::ANALOG_CTRL_IDX ? analogCtrl_q :
		regIdx == slpc_pkg::STATUS_IDX ? statusRead : 8'h00;

	// ****************************************************
	// control field views
	// ****************************************************
	wire logic sleepArm = coreCtrl_q[slpc_pkg::ARM_BIT];
	wire slpc_pkg::slpc_mode_type modeSel =
		slpc_pkg::slpc_mode_type'(coreCtrl_q[slpc_pkg::MODE_LSB +: 2]);
	wire logic levelSense = coreCtrl_q[slpc_pkg::SENSE_LSB +: 2]
		== slpc_pkg::SENSE_LEVEL;
	wire logic cmpOff = analogCtrl_q[slpc_pkg::CMP_OFF_BIT];
	wire logic cmpVref = analogCtrl_q[slpc_pkg::CMP_VREF_BIT];
	wire logic convOn = analogCtrl_q[slpc_pkg::CONV_EN_BIT];
	wire logic convVref = analogCtrl_q[slpc_pkg::CONV_VREF_BIT];
	wire logic gateTimer = clkGate_q[slpc_pkg::TIMER_GATE_BIT];
	wire logic gateConv = clkGate_q[slpc_pkg::CONV_GATE_BIT];

	// ****************************************************
	// wake filtering per sleep mode
	// ****************************************************
	function automatic logic wakeAllowed(
		input slpc_pkg::slpc_mode_type mode,
		input slpc_pkg::slpc_wake_type src,
		input logic level
	);
		logic extLvl;
		logic any;
		extLvl = src.extLow && level;
		any = 1'b0;
		unique case (mode)
			slpc_pkg::MODE_IDLE: begin
				any = src.extEdge || extLvl || src.pinChange
					|| src.memReady || src.converter || src.otherIo
					|| src.watchdog;
			end
			slpc_pkg::MODE_NOISE: begin
				any = src.converter || src.memReady || extLvl
					|| src.pinChange || src.watchdog;
			end
			slpc_pkg::MODE_PDOWN: begin
				any = extLvl || src.pinChange || src.watchdog;
			end
			slpc_pkg::MODE_RSVD: begin
				any = 1'b0;
			end
		endcase
		return any;
	endfunction

	// the level must still stand after two sync stages to count
	wire logic wakeNow = wakeAllowed(sleepMode_q, wakeSync_q,
		levelSense);
	// reserved code never sleeps; arm bit gates the instruction
	wire logic sleepGo = sleepInstr && sleepArm
		&& modeSel != slpc_pkg::MODE_RSVD;
	wire logic sleepPdown = sleepMode_q == slpc_pkg::MODE_PDOWN;
	wire logic enterConvMode = sleepGo && convOn
		&& (modeSel == slpc_pkg::MODE_IDLE
		|| modeSel == slpc_pkg::MODE_NOISE);
	wire logic [15:0] startLoad = bodOffSleep_q
		? 16'(START_CYC + BOD_WAKE_CYC) : 16'(START_CYC);

	// ****************************************************
	// power state machine
	// ****************************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			slpc_pkg::ST_ACTIVE: begin
				if (sleepGo) begin
					state_d = slpc_pkg::ST_SLEEP;
				end
			end
			slpc_pkg::ST_SLEEP: begin
				if (wakeNow) begin
					state_d = slpc_pkg::ST_START;
				end
			end
			slpc_pkg::ST_START: begin
				if (waitCnt_q <= 16'h0001) begin
					state_d = slpc_pkg::ST_HALT;
				end
			end
			slpc_pkg::ST_HALT: begin
				if (haltCnt_q == 3'h1) begin
					state_d = slpc_pkg::ST_ACTIVE;
				end
			end
		endcase
	end

	// clock enables from next state so outputs change with state
	always_comb begin
		clkEn_d = '1;
		if (state_d != slpc_pkg::ST_ACTIVE) begin
			clkEn_d.cpuClk = 1'b0;
			clkEn_d.flashClk = 1'b0;
		end
		if (state_d == slpc_pkg::ST_SLEEP) begin
			if (sleepGo ? modeSel != slpc_pkg::MODE_IDLE
				: sleepMode_q != slpc_pkg::MODE_IDLE) begin
				clkEn_d.ioClk = 1'b0;
			end
			if (sleepGo ? modeSel == slpc_pkg::MODE_PDOWN
				: sleepPdown) begin
				clkEn_d.convClk = 1'b0;
				clkEn_d.osc = 1'b0;
			end
		end
		// timer gate acts in Active and Idle, converter gate also in noise reduction; power-down stops both anyway
		clkEn_d.timerClk = clkEn_d.ioClk && !gateTimer;
		clkEn_d.convGatedClk = clkEn_d.convClk && !gateConv;
	end

	// ****************************************************
	// synchronise wake sources, they come from outside
	// ****************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wakeMeta_q <= '0;
			wakeSync_q <= '0;
		end else begin
			wakeMeta_q <= wakeSrc;
			wakeSync_q <= wakeMeta_q;
		end
	end

	// state, wait counters and clock enables; reset lands in Active,
	// so the core restarts from its reset vector
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= slpc_pkg::ST_ACTIVE;
			sleepMode_q <= slpc_pkg::MODE_IDLE;
			waitCnt_q <= 16'h0000;
			haltCnt_q <= 3'h0;
			clkEn <= '1;
			coreHold <= 1'b0;
		end else begin
			state_q <= state_d;
			clkEn <= clkEn_d;
			coreHold <= state_d != slpc_pkg::ST_ACTIVE;
			if (sleepGo && state_q == slpc_pkg::ST_ACTIVE) begin
				sleepMode_q <= modeSel;
			end
			if (state_q == slpc_pkg::ST_SLEEP && wakeNow) begin
				waitCnt_q <= startLoad;
			end else if (waitCnt_q != 16'h0000) begin
				waitCnt_q <= waitCnt_q - 16'h0001;
			end
			if (state_d == slpc_pkg::ST_HALT
				&& state_q == slpc_pkg::ST_START) begin
				haltCnt_q <= slpc_pkg::HALT_CYC;
			end else if (haltCnt_q != 3'h0) begin
				haltCnt_q <= haltCnt_q - 3'h1;
			end
		end
	end

	// ****************************************************
	// brown-out sleep-off sequence
	// ****************************************************
	wire logic bodUnlock = wrBod && wdat[slpc_pkg::BOD_OFF_BIT]
		&& wdat[slpc_pkg::BOD_UNLOCK_BIT];
	wire logic bodConfirm = wrBod && wdat[slpc_pkg::BOD_OFF_BIT]
		&& !wdat[slpc_pkg::BOD_UNLOCK_BIT] && unlockCnt_q != 3'h0;

	// counter walks 6..4 as arming delay, then 3..1 as active window
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			unlockCnt_q <= 3'h0;
			bodSeq_q <= 3'h0;
			bodOffSleep_q <= 1'b0;
		end else begin
			if (bodUnlock) begin
				unlockCnt_q <= slpc_pkg::UNLOCK_CYC;
			end else if (unlockCnt_q != 3'h0) begin
				unlockCnt_q <= unlockCnt_q - 3'h1;
			end
			if (bodConfirm) begin
				bodSeq_q <= slpc_pkg::BOD_SEQ_LOAD;
			end else if (bodSeq_q != 3'h0) begin
				bodSeq_q <= bodSeq_q - 3'h1;
			end
			if (sleepGo && state_q == slpc_pkg::ST_ACTIVE) begin
				bodOffSleep_q <= bodActive
					&& modeSel == slpc_pkg::MODE_PDOWN;
			end else if (state_q == slpc_pkg::ST_HALT
				&& state_d == slpc_pkg::ST_ACTIVE) begin
				bodOffSleep_q <= 1'b0;
			end
		end
	end

	// ****************************************************
	// software registers and bus answer
	// ****************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			coreCtrl_q <= slpc_pkg::REG_RESET;
			clkGate_q <= slpc_pkg::REG_RESET;
			analogCtrl_q <= slpc_pkg::REG_RESET;
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= busReq;
			rdat_q <= {24'h000000, rdByte};
			if (wrCore) begin
				coreCtrl_q <= wdat & slpc_pkg::CORE_CTRL_MASK;
			end
			if (wrGate) begin
				clkGate_q <= wdat & slpc_pkg::CLK_GATE_MASK;
			end
			if (wrAnalog) begin
				analogCtrl_q <= wdat & slpc_pkg::ANALOG_CTRL_MASK;
			end
		end
	end

	// ****************************************************
	// wake handler strobe, converter and analog enables
	// ****************************************************
	// brown-out off is ended when the sleep state is left at wake, before the core is released
	wire logic bodOn = !(bodOffSleep_q
		&& state_d == slpc_pkg::ST_SLEEP);
	wire logic cmpOn = !cmpOff
		&& !(state_d == slpc_pkg::ST_SLEEP && sleepPdown
		&& !cmpVref);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irqGo_q <= 1'b0;
			convStart_q <= 1'b0;
			convExt_q <= 1'b0;
			brownoutEn_q <= 1'b1;
			comparatorEn_q <= 1'b0;
			vrefEn_q <= 1'b0;
		end else begin
			irqGo_q <= state_q == slpc_pkg::ST_HALT
				&& state_d == slpc_pkg::ST_ACTIVE;
			convStart_q <= enterConvMode
				&& state_q == slpc_pkg::ST_ACTIVE;
			// re-enable marks the next conversion extended; the set
			// wins over the clear by the start
			if (wrAnalog && wdat[slpc_pkg::CONV_EN_BIT] && !convOn) begin
				convExt_q <= 1'b1;
			end else if (convStart_q) begin
				convExt_q <= 1'b0;
			end
			brownoutEn_q <= bodOn;
			comparatorEn_q <= cmpOn;
			vrefEn_q <= bodOn || (cmpOn && cmpVref)
				|| (convOn && convVref);
		end
	end

	// ****************************************************
	// outputs
	// ****************************************************
	assign wbAck = ack_q;
	assign wbDatR = rdat_q;
	assign irqGo = irqGo_q;
	assign convStart = convStart_q;
	assign convExtended = convExt_q;
	assign brownoutEn = brownoutEn_q;
	assign comparatorEn = comparatorEn_q;
	assign vrefEn = vrefEn_q;
	// peripheral register access blocked while its clock is gated
	assign timerRegBlock = clkGate_q[slpc_pkg::TIMER_GATE_BIT];
	assign convRegBlock = clkGate_q[slpc_pkg::CONV_GATE_BIT];
endmodule // slpc_controller

// File: rtl/slpc_pkg.sv
// constants and types for the sleep and power-reduction controller
// Overview of operation
// - sleep instruction only sleeps when the sleep arm bit is one
// - mode 00 Idle: stop cpu and flash clocks, io, converter, osc run
// - mode 01 noise reduction: stop io, cpu, flash; converter, osc run
// - mode 10 power-down: stop oscillator and every generated clock
// - interrupt wake: hold core four cycles past start-up, then handler
// - waking leaves register file and sram untouched
// - reset during sleep wakes and restarts from the reset vector
// - in Idle any enabled interrupt wakes the core
// - noise reduction wakes on converter, mem-ready, ext level, pins, wdog
// - power-down wakes on ext level, pin change, watchdog, resets
// - deep modes accept the external line only in level sensing
// - enabled converter starts a conversion on Idle or noise entry
// - brown-out off right after sleep entry, back on at wake
// - wake after brown-out off sleep is stretched by about 60 us
// - brown-out sleep-off one disables it in power-down, resets zero
// - clock-gate bit stops a peripheral clock and blocks its registers
// - clearing a clock-gate bit resumes the frozen peripheral
// - clock gating acts in Active and Idle; converter gate also in noise reduction
// - converter stays enabled in sleep; re-enable marks extended conv
// - comparator off in power-down unless it uses the reference
// - reference on whenever detector, comparator or converter need it
// - sleep-off armed by unlock then write within four cycles, 3+3 cycles
// - mode code 11 is reserved and never sleeps
// - clock-gate register: timer gate bit 1, converter gate bit 0
package slpc_pkg;
	// ****************************************************
	// register indices, byte address is four times these
	// ****************************************************
	localparam logic [7:0] CORE_CTRL_IDX = 8'h35;
	localparam logic [7:0] CLK_GATE_IDX = 8'h25;
	localparam logic [7:0] BOD_CTRL_IDX = 8'h30;
	localparam logic [7:0] ANALOG_CTRL_IDX = 8'h31;
	localparam logic [7:0] STATUS_IDX = 8'h32;
	localparam logic [7:0] CORE_CTRL_MASK = 8'h7B;
	localparam logic [7:0] CLK_GATE_MASK = 8'h03;
	localparam logic [7:0] ANALOG_CTRL_MASK = 8'h0F;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ****************************************************
	// field positions
	// ****************************************************
	localparam int ARM_BIT = 5;
	localparam int MODE_LSB = 3;
	localparam int SENSE_LSB = 0;
	localparam int TIMER_GATE_BIT = 1;
	localparam int CONV_GATE_BIT = 0;
	localparam int BOD_OFF_BIT = 1;
	localparam int BOD_UNLOCK_BIT = 0;
	localparam int CMP_OFF_BIT = 0;
	localparam int CMP_VREF_BIT = 1;
	localparam int CONV_EN_BIT = 2;
	localparam int CONV_VREF_BIT = 3;
	localparam logic [1:0] SENSE_LEVEL = 2'h0;
	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int BOD_WAKE_US = 60;
	localparam int BOD_WAKE_CYC =
		(BOD_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_CYC = 16;
	localparam logic [2:0] HALT_CYC = 3'h4;
	localparam logic [2:0] UNLOCK_CYC = 3'h4;
	localparam logic [2:0] BOD_SEQ_LOAD = 3'h6;
	localparam logic [2:0] BOD_ACTIVE_MAX = 3'h3;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_NOISE = 2'b01,
		MODE_PDOWN = 2'b10,
		MODE_RSVD = 2'b11
	} slpc_mode_type;

	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_SLEEP = 2'b01,
		ST_START = 2'b10,
		ST_HALT = 2'b11
	} slpc_state_type;

	// pending, enabled wake requests
	typedef struct packed {
		logic extEdge;
		logic extLow;
		logic pinChange;
		logic memReady;
		logic converter;
		logic otherIo;
		logic watchdog;
	} slpc_wake_type;

	// clock and oscillator enables
	typedef struct packed {
		logic cpuClk;
		logic flashClk;
		logic ioClk;
		logic convClk;
		logic osc;
		logic timerClk;
		logic convGatedClk;
	} slpc_clk_type;
endpackage // slpc_pkg

// File: tb/slpc_wake_model.sv
// wake request model: interrupt and pin sources facing the controller
module slpc_wake_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire slpc_pkg::slpc_wake_type raiseReq,
	input wire logic clearAll,
	input wire logic irqGo,
	output slpc_pkg::slpc_wake_type wakeSrc
);
	slpc_pkg::slpc_wake_type pend_q;

	assign wakeSrc = pend_q;

	// a request level stays up until the handler runs, never shorter than
	// the wake synchroniser needs; unserved requests linger like real flags
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pend_q <= '0;
		end else if (clearAll || irqGo) begin
			pend_q <= '0;
		end else begin
			pend_q <= pend_q | raiseReq;
		end
	end
endmodule // slpc_wake_model

// File: tb/slpc_controller_chk.sv
// port assertions for the sleep controller
module slpc_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbAck,
	input wire slpc_pkg::slpc_clk_type clkEn,
	input wire logic coreHold,
	input wire logic irqGo,
	input wire logic convStart,
	input wire logic brownoutEn,
	input wire logic vrefEn,
	input wire logic timerRegBlock,
	input wire logic convRegBlock
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// bus answer is exactly one cycle late and one cycle wide
	a_ack_answer: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (wbAck |=> !wbAck)
		else $error("ack longer than one cycle");
	// oscillator off means cpu, flash, io and converter clocks are off
	a_pdown_clocks: assert property (!clkEn.osc |-> !(clkEn.cpuClk ||
		clkEn.flashClk || clkEn.ioClk || clkEn.convClk))
		else $error("clock running with oscillator stopped");
	a_sleep_entry: assert property ($rose(coreHold) && clkEn.osc |->
		!clkEn.cpuClk && !clkEn.flashClk && clkEn.convClk)
		else $error("wrong clocks on shallow sleep entry");
	// sync, start-up and four halt cycles keep the core held a while
	a_hold_span: assert property ($rose(coreHold) |-> coreHold[*6])
		else $error("core released too soon");
	a_wake_handler: assert property ($fell(coreHold) |->
		irqGo && brownoutEn)
		else $error("release without handler or detector");
	a_irq_pulse: assert property (irqGo |=> !irqGo)
		else $error("handler start longer than one cycle");
	a_conv_entry: assert property (convStart |-> coreHold &&
		!clkEn.cpuClk && clkEn.convClk && clkEn.osc)
		else $error("conversion start outside shallow sleep");
	a_vref_need: assert property (brownoutEn ##1 brownoutEn |-> vrefEn)
		else $error("reference off while detector on");
	a_timer_gate: assert property (timerRegBlock ##1 timerRegBlock |->
		!clkEn.timerClk)
		else $error("timer clock runs while gated");
	a_conv_gate: assert property (convRegBlock ##1 convRegBlock |->
		!clkEn.convGatedClk)
		else $error("converter clock runs while gated");
endmodule // slpc_chk

bind slpc_controller slpc_chk u_chk (.ref_clk(ref_clk), .nrst(nrst),
	.wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .clkEn(clkEn),
	.coreHold(coreHold), .irqGo(irqGo), .convStart(convStart),
	.brownoutEn(brownoutEn), .vrefEn(vrefEn),
	.timerRegBlock(timerRegBlock), .convRegBlock(convRegBlock));

// File: tb/tb.sv
// self-checking bench for the sleep controller
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int ST = 2;
	localparam int BW = 8;
	logic ref_clk, nrst, wbWe, wbCyc, wbStb, wbAck, sleepInstr, clearAll;
	logic coreHold, irqGo, convStart, convExtended, brownoutEn;
	logic comparatorEn, vrefEn, timerRegBlock, convRegBlock, gotIrq, seenConv;
	logic [31:0] wbAdr, wbDatW, wbDatR;
	logic [7:0] q;
	slpc_pkg::slpc_wake_type raiseReq, wakeSrc;
	slpc_pkg::slpc_clk_type clkEn;
	int fail_count, checks_done, lat;
	logic [6:0] badSrc [3] = '{7'h00, 7'h42, 7'h4C};
	logic [6:0] okSrc [3] = '{7'h02, 7'h08, 7'h20};
	logic [4:0] runClk [3] = '{5'h07, 5'h03, 5'h00};

	// short start-up and detector counts keep the run brief
	slpc_controller #(.START_CYC(ST), .BOD_WAKE_CYC(BW)) dut (
		.ref_clk(ref_clk), .nrst(nrst), .wbAdr(wbAdr), .wbDatW(wbDatW),
		.wbDatR(wbDatR), .wbWe(wbWe), .wbSel(4'hF), .wbCyc(wbCyc),
		.wbStb(wbStb), .wbAck(wbAck), .sleepInstr(sleepInstr),
		.wakeSrc(wakeSrc), .clkEn(clkEn), .coreHold(coreHold), .irqGo(irqGo),
		.convStart(convStart), .convExtended(convExtended),
		.brownoutEn(brownoutEn), .comparatorEn(comparatorEn), .vrefEn(vrefEn),
		.timerRegBlock(timerRegBlock), .convRegBlock(convRegBlock));
	slpc_wake_model wsrc (.ref_clk(ref_clk), .nrst(nrst), .raiseReq(raiseReq),
		.clearAll(clearAll), .irqGo(irqGo), .wakeSrc(wakeSrc));

	// clock and conversion-start catcher
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (convStart === 1'b1) seenConv <= 1'b1;

	// ****************************************************
	// tasks
	// ****************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one classic cycle; ack and read data are taken at the rising edge
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge ref_clk);
		wbAdr <= {22'h0, idx, 2'h0};
		wbDatW <= {24'h0, d};
		wbWe <= we;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			summarize();
		end
		q = wbDatR[7:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00);
		check(q, e);
	endtask
	task automatic sleepCmd(input logic arm, input logic [1:0] m);
		wb(1'b1, slpc_pkg::CORE_CTRL_IDX, {2'b00, arm, m, 3'b000});
		seenConv = 1'b0;
		@(posedge ref_clk);
		sleepInstr <= 1'b1;
		@(posedge ref_clk);
		sleepInstr <= 1'b0;
		// one more edge so the conversion-start catcher has seen the pulse
		repeat (2) @(negedge ref_clk);
	endtask
	// raise a request, then wait a bounded time for the handler start
	task automatic wake(input logic [6:0] s, input int lim);
		@(posedge ref_clk);
		raiseReq <= s;
		@(posedge ref_clk);
		raiseReq <= 7'h00;
		gotIrq = 1'b0;
		for (lat = 0; lat < lim && !gotIrq; lat++) begin
			@(negedge ref_clk);
			gotIrq = (irqGo === 1'b1);
		end
	endtask

	// ****************************************************
	// sequence
	// ****************************************************
	initial begin
		{nrst, wbWe, wbCyc, wbStb, sleepInstr, clearAll, seenConv} = '0;
		{wbAdr, wbDatW, raiseReq} = '0;
		{fail_count, checks_done} = '0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		@(negedge ref_clk);
		check(clkEn, 7'h7F);
		check({coreHold, brownoutEn}, 2'b01);
		rd(slpc_pkg::CORE_CTRL_IDX, 8'h00);
		wb(1'b1, 8'h10, 8'hFF);
		rd(8'h10, 8'h00);
		$display("test reset values done");
		wb(1'b1, slpc_pkg::CLK_GATE_IDX, 8'hFF);
		rd(slpc_pkg::CLK_GATE_IDX, 8'h03);
		check({timerRegBlock, convRegBlock, clkEn[1:0]}, 4'hC);
		wb(1'b1, slpc_pkg::CLK_GATE_IDX, 8'h00);
		repeat (2) @(negedge ref_clk);
		check({timerRegBlock, convRegBlock, clkEn[1:0]}, 4'h3);
		$display("test clock gating done");
		sleepCmd(1'b0, 2'b00);
		check(coreHold, 1'b0);
		sleepCmd(1'b1, 2'b11);
		check(coreHold, 1'b0);
		$display("test refused sleep done");
		wb(1'b1, slpc_pkg::ANALOG_CTRL_IDX, 8'h04);
		@(negedge ref_clk);
		check(convExtended, 1'b1);
		for (int m = 0; m < 3; m++) begin
			sleepCmd(1'b1, 2'(m));
			check({coreHold, clkEn[6:2]}, {1'b1, runClk[m]});
			check(seenConv, m != 2);
			check({comparatorEn && m == 2, brownoutEn}, 2'b01);
			wake(badSrc[m], 30);
			check({gotIrq, coreHold}, 2'b01);
			wake(okSrc[m], 100);
			check({gotIrq, coreHold}, 2'b10);
			rd(slpc_pkg::CORE_CTRL_IDX, {3'b001, 2'(m), 3'b000});
			$display("test sleep mode %0d done", m);
		end
		wb(1'b1, slpc_pkg::CORE_CTRL_IDX, 8'h30);
		wb(1'b1, slpc_pkg::BOD_CTRL_IDX, 8'h03);
		wb(1'b1, slpc_pkg::BOD_CTRL_IDX, 8'h02);
		repeat (3) @(posedge ref_clk);
		sleepInstr <= 1'b1;
		@(posedge ref_clk);
		sleepInstr <= 1'b0;
		repeat (3) @(negedge ref_clk);
		check(brownoutEn, 1'b0);
		wake(7'h20, 200);
		check({gotIrq, brownoutEn}, 2'b11);
		check(lat >= BW + ST + 4, 1'b1);
		$display("test brown-out sleep done");
		sleepCmd(1'b1, 2'b01);
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		@(negedge ref_clk);
		check({coreHold, clkEn}, 8'h7F);
		rd(slpc_pkg::CORE_CTRL_IDX, 8'h00);
		$display("test reset in sleep done");
		summarize();
	end
endmodule // tb
